// file: fdr_host_model.sv
/* fdr_host_model: host processor doing byte i/o cycles on the front end.
   Assumes clk_sys from the bench; strobes held until the answer is seen, for at most 8 edges. */
`timescale 1ns/1ps
module fdr_host_model (
   // clock
   input wire logic         clk_sys,
   // read side
   input wire logic [7:0]   host_data_out,
   input wire logic         host_data_oe,
   // host pins
   output logic [15:0]      host_addr,
   output logic             host_aen,
   output logic             host_ior_n,
   output logic             host_iow_n,
   output logic [7:0]       host_data_in
);
   initial begin
      host_addr = 16'hffff;
      host_aen = 1'b0;
      host_ior_n = 1'b1;
      host_iow_n = 1'b1;
      host_data_in = 8'h00;
   end

   // one byte cycle; strobe low until oe or 8 edges, then high 6 edges
   task automatic cyc(input logic rd, input logic aen, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic ok);
      q = 8'h00;
      ok = 1'b0;
      @(posedge clk_sys);
      #2;
      host_addr = a;
      host_aen = aen;
      host_data_in = rd ? ~host_data_in : d;
      if (rd) host_ior_n = 1'b0;
      else host_iow_n = 1'b0;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge clk_sys);
         if (rd && host_data_oe === 1'b1) begin
            ok = 1'b1;
            q = host_data_out;
         end
      end
      #2;
      host_ior_n = 1'b1;
      host_iow_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      // released data lines must not keep the last byte
      #2 host_data_in = ~host_data_in;
   endtask
endmodule

// file: fdr_pkg.sv
/*
 * fdr_pkg: constants, register offsets, configuration indices and mode types
 * for the floppy controller host register front end.
 * Assumes a byte-wide host i/o bus with 16-bit address qualification.
 */
package fdr_pkg;

   // configuration access port pairs (index at +0, data at +1)
   localparam logic [15:0] CFG_PORT_PRI    = 16'h03f0;
   localparam logic [15:0] CFG_PORT_ALT    = 16'h0370;
   localparam logic [15:0] CFG_DATA_STEP   = 16'h0001;
   localparam logic [7:0]  CFG_KEY_ENTER   = 8'h55;
   localparam logic [7:0]  CFG_KEY_EXIT    = 8'haa;

   // configuration register indices
   localparam logic [7:0]  CR_MODE         = 8'h03;
   localparam logic [7:0]  CR_FDC_BASE     = 8'h20;
   localparam logic [7:0]  CR_PAR_BASE     = 8'h23;
   localparam logic [7:0]  CR_SER1_BASE    = 8'h24;
   localparam logic [7:0]  CR_SER2_BASE    = 8'h25;
   localparam int          CR3_IDENT_BIT   = 0;
   localparam int          CR3_ENC_BIT     = 1;
   localparam int          CR3_ENH_BIT     = 5;
   localparam logic [7:0]  CR3_RESET       = 8'h03;
   localparam logic [7:0]  BASE_RESET      = 8'h00;

   // floppy register offsets from the programmed base
   localparam logic [2:0]  OFS_STATUS_A    = 3'h0;
   localparam logic [2:0]  OFS_STATUS_B    = 3'h1;
   localparam logic [2:0]  OFS_DIG_OUT     = 3'h2;
   localparam logic [2:0]  OFS_TAPE        = 3'h3;
   localparam logic [2:0]  OFS_MSR_RATE    = 3'h4;
   localparam logic [2:0]  OFS_FIFO        = 3'h5;
   localparam logic [2:0]  OFS_DIN_CCTL    = 3'h7;

   // floppy register fields and reset values
   localparam int          DOR_DMAEN_BIT   = 3;
   localparam int          DOR_NRESET_BIT  = 2;
   localparam logic [7:0]  DOR_RESET       = 8'h00;
   localparam logic [7:0]  TDR_RESET       = 8'h00;
   localparam logic [7:0]  TDR_NORMAL_MASK = 8'h03;
   localparam logic [7:0]  RATE_RESET      = 8'h02;
   localparam logic [7:0]  CCTL_RESET      = 8'h02;
   localparam int          DIN_CHG_BIT     = 7;

   // cycles the strap pin needs to pass the input synchroniser
   localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

   typedef enum logic [1:0] {FDR_MODE_AT, FDR_MODE_PS2, FDR_MODE_M30} fdr_mode_e;
   typedef enum logic [1:0] {FDR_CFG_IDLE, FDR_CFG_KEY1, FDR_CFG_ACTIVE} fdr_cfg_e;

endpackage

// file: fdr_sticky.sv
/*
 * fdr_sticky: one latched status flag, set by a hardware event and cleared
 * by a register read.
 * Assumes set and clr are single-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
module fdr_sticky (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // event and clear
   input  wire logic set,
   input  wire logic clr,
   // flag
   output logic      q
);
   // set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end
endmodule

// file: fdr_sync.sv
/*
 * fdr_sync: three flip-flop input synchroniser; a bit takes its new level
 * once the second and third stages agree.
 * Assumes inputs are asynchronous to clk_sys and reset is synchronous.
 */
`timescale 1ns/1ps
module fdr_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic   clk_sys,
   input  wire logic   rst,
   // pin bundle
   fdr_sync_if.syncer  sp
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] settled;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= sp.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit that still disagrees keeps its last settled level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         settled <= '0;
      end else begin
         settled <= (stage2 & stage3) | (settled & (stage2 ^ stage3));
      end
   end

   assign sp.clean = settled;
endmodule

// file: fdr_sync_if.sv
/*
 * fdr_sync_if: carries a bundle of raw pin levels into the synchroniser and
 * its settled copy back to the user.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface fdr_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport syncer (input raw, output clean);
   modport user   (output raw, input clean);
endinterface

// file: fdr_top.sv
/*
 * fdr_top: host register front end of the floppy controller. Decodes the
 * configuration port and the seven floppy register offsets, derives the floppy and
 * interface modes and drives the mode-dependent interrupt, dma, terminal
 * count and density pins.
 * Assumes the controller core sits on clk_sys and hands its state over as
 * active-high levels; host strobes, address, data and drive pins are async.
 */
// Function
// [RL1] config port at 3F0/3F1 or 370/371, write-only
// [RL2] config writes only in config state
// [RL3] blocks disabled until base address programmed
// [RL4] floppy, serial, parallel bases are relocatable
// [RL5] all registers are eight bits wide
// [RL6] two floppy modes, three interface modes
// [RL7] enhanced bit selects tape register layout
// [RL8] first mode: dma bit honoured, active-high pins
// [RL9] second mode: dma ignored, always drive, active-low
// [RL10] third mode: dma honoured, tc high, density low
// [RL11] offsets 0,1,2,3,5 decode listed registers
// [RL12] offsets 4 and 7 split read/write
// [RL13] offset 6 and others never answer
// [RL14] status A undriven in first mode
// [RL15] status A bit order in second mode
// [RL16] status A reset values in second mode
// [RL17] second-drive flag reads one
// [RL18] irq pending mirrors irq; direction one inward
// [RL19] drive status sampled live per read
`timescale 1ns/1ps
module fdr_top
   import fdr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // host i/o bus
   input  wire logic [15:0] host_addr,
   input  wire logic       host_aen,
   input  wire logic       host_ior_n,
   input  wire logic       host_iow_n,
   input  wire logic [7:0] host_data_in,
   output logic [7:0]      host_data_out,
   output logic            host_data_oe,
   // configuration port strap
   input  wire logic       cfg_port_alt,
   // drive interface inputs
   input  wire logic       track_zero_n,
   input  wire logic       index_pulse_n,
   input  wire logic       write_protect_n,
   input  wire logic       disk_change_n,
   input  wire logic       terminal_count_in,
   // controller core state
   input  wire logic       core_irq,
   input  wire logic       core_drq,
   input  wire logic       core_step,
   input  wire logic       core_dir_in,
   input  wire logic       core_head_side,
   input  wire logic       core_wgate,
   input  wire logic       core_rdata,
   input  wire logic       core_wdata,
   input  wire logic       core_density_hi,
   input  wire logic [7:0] core_main_status,
   input  wire logic [7:0] core_fifo_rd_data,
   // to controller core
   output logic            core_fifo_rd,
   output logic            core_fifo_wr,
   output logic [7:0]      core_fifo_wr_data,
   output logic            core_soft_reset,
   output logic            core_tc,
   output logic [7:0]      rate_select,
   output logic [7:0]      config_control,
   output logic [3:0]      motor_enable,
   output logic [3:0]      drive_select,
   output logic            enhanced_floppy,
   // mode-dependent pins
   output logic            floppy_irq_out,
   output logic            floppy_irq_oe,
   output logic            dma_request_out,
   output logic            dma_request_oe,
   output logic            density_select_out,
   // configuration results
   output logic            cfg_state_active,
   output logic            fdc_enabled,
   output logic [7:0]      par_base,
   output logic [7:0]      ser1_base,
   output logic [7:0]      ser2_base
);
   localparam int SW = 33;

   fdr_sync_if #(.W(SW)) pins ();

   logic        aen_c;
   logic        ior_n_c;
   logic        iow_n_c;
   logic [15:0] addr_c;
   logic [7:0]  din_c;
   logic        trk0_n_c;
   logic        index_n_c;
   logic        wp_n_c;
   logic        chg_n_c;
   logic        tc_pin_c;
   logic        strap_c;

   logic        rd_prev;
   logic        wr_prev;
   logic        rd_evt;
   logic        wr_evt;
   logic [1:0]  strap_cnt;
   logic        port_alt;

   fdr_cfg_e    cfg_state;
   logic [7:0]  cfg_index;
   logic [7:0]  cr_mode;
   logic [7:0]  fdc_base;

   fdr_mode_e   mode;
   logic        dma_gate;
   logic [15:0] cfg_port;
   logic        cfg_idx_hit;
   logic        cfg_dat_hit;
   logic        fdc_hit;
   logic [2:0]  ofs;

   logic [7:0]  digital_output_reg;
   logic [7:0]  tape_drive_reg;
   logic [7:0]  next_rd_data;
   logic        next_rd_drive;
   logic [7:0]  status_a;
   logic [7:0]  status_b;
   logic        din_read;

   logic        step_prev;
   logic        wgate_prev;
   logic        rdata_prev;
   logic        wdata_prev;
   logic        step_ff;
   logic        wgate_ff;
   logic        rdata_ff;
   logic        wdata_ff;
   logic        rdata_tgl;
   logic        wdata_tgl;

   // all pin inputs pass one synchroniser bundle
   assign pins.raw = {host_aen, host_ior_n, host_iow_n, host_addr, host_data_in, track_zero_n,
                      index_pulse_n, write_protect_n, disk_change_n, terminal_count_in,
                      cfg_port_alt};
   assign {aen_c, ior_n_c, iow_n_c, addr_c, din_c, trk0_n_c, index_n_c, wp_n_c, chg_n_c,
           tc_pin_c, strap_c} = pins.clean;

   fdr_sync #(.W(SW)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sp      (pins.syncer)
   );

   // host strobes: an access starts on the settled falling edge
   // held as already low in reset: cleared sync stages read as strobes low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_prev <= 1'b1;
         wr_prev <= 1'b1;
      end else begin
         rd_prev <= ~ior_n_c;
         wr_prev <= ~iow_n_c;
      end
   end
   assign rd_evt = ~ior_n_c & ~rd_prev;
   assign wr_evt = ~iow_n_c & ~wr_prev;

   // strap is caught after the synchroniser has settled, never under reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strap_cnt <= 2'h0;
         port_alt  <= 1'b0;
      end else if (strap_cnt != STRAP_SETTLE) begin
         strap_cnt <= strap_cnt + 2'h1;
      end else begin
         port_alt  <= strap_c;
      end
   end

   // address decode
   assign cfg_port    = port_alt ? CFG_PORT_ALT : CFG_PORT_PRI; // RL1
   assign cfg_idx_hit = ~aen_c & (addr_c == cfg_port);
   assign cfg_dat_hit = ~aen_c & (addr_c == 16'(cfg_port + CFG_DATA_STEP));
   assign fdc_enabled = (fdc_base != BASE_RESET); // RL3
   assign fdc_hit     = ~aen_c & fdc_enabled & (addr_c[15:11] == 5'h00)
                        & (addr_c[10:3] == fdc_base); // RL4
   assign ofs         = addr_c[2:0];

   // configuration state: two enter keys open it, the exit key closes it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_state <= FDR_CFG_IDLE;
         cfg_index <= 8'h00;
      end else if (wr_evt && cfg_idx_hit) begin
         case (cfg_state)
            FDR_CFG_IDLE: begin
               if (din_c == CFG_KEY_ENTER) begin
                  cfg_state <= FDR_CFG_KEY1;
               end
            end
            FDR_CFG_KEY1: begin
               cfg_state <= (din_c == CFG_KEY_ENTER) ? FDR_CFG_ACTIVE : FDR_CFG_IDLE;
            end
            FDR_CFG_ACTIVE: begin
               if (din_c == CFG_KEY_EXIT) begin
                  cfg_state <= FDR_CFG_IDLE;
               end else begin
                  cfg_index <= din_c;
               end
            end
            default: begin
               cfg_state <= FDR_CFG_IDLE;
            end
         endcase
      end
   end
   assign cfg_state_active = (cfg_state == FDR_CFG_ACTIVE);

   // configuration registers; the floppy path keeps running meanwhile
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cr_mode   <= CR3_RESET;
         fdc_base  <= BASE_RESET; // RL3
         par_base  <= BASE_RESET;
         ser1_base <= BASE_RESET;
         ser2_base <= BASE_RESET;
      end else if (wr_evt && cfg_dat_hit && cfg_state_active) begin // RL2
         case (cfg_index)
            CR_MODE:      cr_mode   <= din_c;
            CR_FDC_BASE:  fdc_base  <= din_c; // RL4
            CR_PAR_BASE:  par_base  <= din_c; // RL4
            CR_SER1_BASE: ser1_base <= din_c; // RL4
            CR_SER2_BASE: ser2_base <= din_c; // RL4
            default: begin
            end
         endcase
      end
   end

   // interface mode; ident high with encoding low is undefined and taken as the first mode
   always_comb begin
      if (!cr_mode[CR3_ENC_BIT] && !cr_mode[CR3_IDENT_BIT]) begin
         mode = FDR_MODE_M30; // RL10
      end else if (cr_mode[CR3_ENC_BIT] && !cr_mode[CR3_IDENT_BIT]) begin
         mode = FDR_MODE_PS2; // RL9
      end else begin
         mode = FDR_MODE_AT; // RL8
      end
   end
   assign enhanced_floppy = cr_mode[CR3_ENH_BIT]; // RL6 RL7

   // mode-dependent pins
   assign dma_gate           = (mode == FDR_MODE_PS2) | digital_output_reg[DOR_DMAEN_BIT]; // RL8 RL9 RL10
   assign floppy_irq_out     = core_irq;
   assign floppy_irq_oe      = dma_gate;
   assign dma_request_out    = core_drq;
   assign dma_request_oe     = dma_gate;
   assign core_tc            = dma_gate & ((mode == FDR_MODE_PS2) ? ~tc_pin_c : tc_pin_c); // RL9
   assign density_select_out = (mode == FDR_MODE_AT) ? core_density_hi : ~core_density_hi; // RL10

   // floppy write registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         digital_output_reg            <= DOR_RESET;
         tape_drive_reg            <= TDR_RESET;
         rate_select    <= RATE_RESET;
         config_control <= CCTL_RESET;
      end else if (wr_evt && fdc_hit) begin
         case (ofs) // RL11 RL12
            OFS_DIG_OUT:  digital_output_reg            <= din_c;
            OFS_TAPE:     tape_drive_reg            <= din_c;
            OFS_MSR_RATE: rate_select    <= din_c;
            OFS_DIN_CCTL: config_control <= din_c;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         core_fifo_wr      <= 1'b0;
         core_fifo_rd      <= 1'b0;
         core_fifo_wr_data <= 8'h00;
      end else begin
         core_fifo_wr <= wr_evt & fdc_hit & (ofs == OFS_FIFO); // RL11
         core_fifo_rd <= rd_evt & fdc_hit & (ofs == OFS_FIFO);
         if (wr_evt && fdc_hit && ofs == OFS_FIFO) begin
            core_fifo_wr_data <= din_c;
         end
      end
   end

   assign core_soft_reset = ~digital_output_reg[DOR_NRESET_BIT];
   assign motor_enable    = digital_output_reg[7:4];
   assign drive_select    = 4'(4'h1 << digital_output_reg[1:0]);

   // latched drive events, cleared by a digital input read
   assign din_read = rd_evt & fdc_hit & (ofs == OFS_DIN_CCTL);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         step_prev  <= 1'b0;
         wgate_prev <= 1'b0;
         rdata_prev <= 1'b0;
         wdata_prev <= 1'b0;
         rdata_tgl  <= 1'b0;
         wdata_tgl  <= 1'b0;
      end else begin
         step_prev  <= core_step;
         wgate_prev <= core_wgate;
         rdata_prev <= core_rdata;
         wdata_prev <= core_wdata;
         rdata_tgl  <= rdata_tgl ^ (rdata_prev & ~core_rdata);
         wdata_tgl  <= wdata_tgl ^ (wdata_prev & ~core_wdata);
      end
   end

   fdr_sticky u_step (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (core_step & ~step_prev),
      .clr     (din_read),
      .q       (step_ff)
   );

   fdr_sticky u_wgate (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (core_wgate & ~wgate_prev),
      .clr     (din_read),
      .q       (wgate_ff)
   );

   fdr_sticky u_rdata (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (rdata_prev & ~core_rdata),
      .clr     (din_read),
      .q       (rdata_ff)
   );

   fdr_sticky u_wdata (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (wdata_prev & ~core_wdata),
      .clr     (din_read),
      .q       (wdata_ff)
   );

   // status registers built from live levels and the latched drive events at the moment of the read
   always_comb begin
      if (mode == FDR_MODE_M30) begin
         status_a = {core_irq, core_drq, step_ff, ~trk0_n_c, ~core_head_side, ~index_n_c,
                     ~wp_n_c, ~core_dir_in};
         status_b = {1'b1, ~drive_select[1], ~drive_select[0], wdata_ff, rdata_ff, wgate_ff,
                     ~drive_select[3], ~drive_select[2]};
      end else begin
         status_a = {core_irq, 1'b1, core_step, trk0_n_c, core_head_side, index_n_c,
                     wp_n_c, core_dir_in}; // RL15 RL16 RL17 RL18 RL19
         status_b = {2'b11, digital_output_reg[0], wdata_tgl, rdata_tgl, core_wgate, digital_output_reg[5], digital_output_reg[4]};
      end
   end

   always_comb begin
      next_rd_data  = 8'h00;
      next_rd_drive = 1'b1;
      case (ofs) // RL11 RL12 RL13
         OFS_STATUS_A: begin
            next_rd_data  = status_a;
            next_rd_drive = (mode != FDR_MODE_AT); // RL14
         end
         OFS_STATUS_B: begin
            next_rd_data  = status_b;
            next_rd_drive = (mode != FDR_MODE_AT);
         end
         OFS_DIG_OUT:  next_rd_data = digital_output_reg;
         OFS_TAPE:     next_rd_data = enhanced_floppy ? tape_drive_reg : (tape_drive_reg & TDR_NORMAL_MASK); // RL7
         OFS_MSR_RATE: next_rd_data = core_main_status;
         OFS_FIFO:     next_rd_data = core_fifo_rd_data;
         OFS_DIN_CCTL: next_rd_data = {~chg_n_c, 7'h00};
         default:      next_rd_drive = 1'b0; // RL13
      endcase
   end

   // read data is captured at the strobe edge and driven while the strobe stays low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         host_data_out <= 8'h00;
         host_data_oe  <= 1'b0;
      end else if (rd_evt) begin
         host_data_out <= next_rd_data; // RL5 RL19
         host_data_oe  <= fdc_hit & next_rd_drive; // RL1 RL13
      end else if (ior_n_c) begin
         host_data_oe  <= 1'b0;
      end
   end
endmodule

// file: fdr_top_asserts.sv
/* fdr_top_asserts: port-level checks of the floppy register front end.
   Assumes it is bound to fdr_top, one clk_sys domain, synchronous rst. */
`timescale 1ns/1ps
module fdr_top_asserts (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // host bus
   input wire logic [15:0] host_addr,
   input wire logic        host_aen,
   input wire logic        host_ior_n,
   input wire logic        host_iow_n,
   input wire logic        host_data_oe,
   // core side
   input wire logic        core_irq,
   input wire logic        core_drq,
   input wire logic        core_density_hi,
   input wire logic        core_tc,
   input wire logic        core_fifo_rd,
   input wire logic [3:0]  drive_select,
   // mode pins
   input wire logic        floppy_irq_out,
   input wire logic        floppy_irq_oe,
   input wire logic        dma_request_out,
   input wire logic        dma_request_oe,
   input wire logic        density_select_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_read_cause: assert property (
      $rose(host_data_oe) |-> $past(host_ior_n) == 1'b0 && $past(host_ior_n, 2) == 1'b0
                              && host_iow_n)
      else $error("data bus driven without a settled read");
   chk_no_reserved: assert property (
      $rose(host_data_oe) |-> $past(host_addr[2:0], 2) != 3'h6 && !$past(host_aen, 2))
      else $error("reserved offset or dma cycle answered");
   chk_sra_float: assert property (
      $rose(host_data_oe) && density_select_out == core_density_hi
      |-> $past(host_addr[2:0], 2) != 3'h0)
      else $error("status a answered in first interface mode");
   chk_oe_stands: assert property (host_data_oe && !host_ior_n |=> host_data_oe)
      else $error("data bus dropped during read");
   chk_oe_release: assert property (host_ior_n [*6] |-> !host_data_oe)
      else $error("data bus still driven after read ended");
   chk_irq_follow: assert property (
      floppy_irq_out == core_irq && dma_request_out == core_drq)
      else $error("irq or drq level differs from core");
   chk_gate_pair: assert property (floppy_irq_oe == dma_request_oe)
      else $error("irq and drq drive enables disagree");
   chk_tc_gated: assert property (!floppy_irq_oe |-> !core_tc)
      else $error("terminal count passed with dma gate off");
   chk_fifo_pulse: assert property (core_fifo_rd |=> !core_fifo_rd)
      else $error("fifo read pulse too long");
   chk_fifo_cause: assert property (
      $rose(core_fifo_rd) |-> $past(host_ior_n, 3) == 1'b0 && $past(host_addr[2:0], 3) == 3'h5)
      else $error("fifo read without data port read");
   chk_drive_onehot: assert property ($onehot(drive_select))
      else $error("drive select not one-hot");

   cover property ($rose(host_data_oe));
   cover property (core_fifo_rd);
   cover property ($rose(floppy_irq_oe));
endmodule

// file: tb_top.sv
/* tb_top: directed bench for fdr_top through host byte cycles.
   Assumes fdr_pkg, fdr_host_model and the checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
   import fdr_pkg::*;
   localparam logic [15:0] FB = 16'h0230;
   logic        clk_sys, rst, host_aen, host_ior_n, host_iow_n, host_data_oe, cfg_port_alt, ok;
   logic [15:0] host_addr;
   logic [7:0]  host_data_in, host_data_out, core_main_status, core_fifo_rd_data, q;
   logic [7:0]  core_fifo_wr_data, rate_select, config_control, par_base, ser1_base, ser2_base;
   logic [3:0]  motor_enable, drive_select;
   logic [6:0]  p;
   logic        track_zero_n, index_pulse_n, write_protect_n, disk_change_n, terminal_count_in;
   logic        core_irq, core_drq, core_step, core_dir_in, core_head_side, core_wgate;
   logic        core_rdata, core_wdata, core_density_hi, core_fifo_rd, core_fifo_wr;
   logic        core_soft_reset, core_tc, enhanced_floppy, floppy_irq_out, floppy_irq_oe;
   logic        dma_request_out, dma_request_oe, density_select_out, cfg_state_active;
   logic        fdc_enabled;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;

   fdr_top i_fdr_top (.*);
   fdr_host_model i_fdr_host_model (.*);

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_fdr_host_model.cyc(1'b0, 1'b0, a, d, q, ok);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
      i_fdr_host_model.cyc(1'b1, 1'b0, a, 8'h00, q, ok);
      chk({7'h0, ok}, {7'h0, hit});
      if (hit) chk(q, exp);
   endtask

   // key in, one index/data pair, key out
   task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
      logic [15:0] cp;
      cp = cfg_port_alt ? CFG_PORT_ALT : CFG_PORT_PRI;
      wr(cp, CFG_KEY_ENTER);
      wr(cp, CFG_KEY_ENTER);
      wr(cp, idx);
      wr(cp + CFG_DATA_STEP, val);
      wr(cp, CFG_KEY_EXIT);
   endtask

   task automatic settle;
      repeat (5) @(posedge clk_sys);
      #2;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict;
      end
   end

   initial begin
      rst = 1'b1;
      cfg_port_alt = 1'b0;
      {track_zero_n, index_pulse_n, write_protect_n, disk_change_n, terminal_count_in} = 5'h1e;
      {core_irq, core_drq, core_step, core_dir_in, core_head_side} = 5'h00;
      {core_wgate, core_rdata, core_wdata, core_density_hi} = 4'h0;
      core_main_status = 8'h81;
      core_fifo_rd_data = 8'h3c;
      repeat (16) @(posedge clk_sys);
      #2 rst = 1'b0;
      settle;
      chk({host_data_oe, floppy_irq_oe, core_soft_reset, fdc_enabled, 4'h0}, 8'h20);
      chk(rate_select, RATE_RESET);
      chk(config_control, CCTL_RESET);
      chk({motor_enable, drive_select}, 8'h01);
      rd(FB + 16'h4, 8'h00, 1'b0);
      rd(CFG_PORT_PRI, 8'h00, 1'b0);
      wr(CFG_PORT_PRI, CR_FDC_BASE);
      wr(CFG_PORT_PRI + CFG_DATA_STEP, 8'h46);
      chk({7'h0, fdc_enabled}, 8'h00);
      cfg(CR_FDC_BASE, 8'h46);
      cfg(CR_PAR_BASE, 8'h12);
      cfg(CR_SER1_BASE, 8'h34);
      cfg(CR_SER2_BASE, 8'h56);
      chk({7'h0, fdc_enabled}, 8'h01);
      chk(par_base, 8'h12);
      chk(ser1_base, 8'h34);
      chk(ser2_base, 8'h56);
      // first interface mode is the reset mode
      rd(FB, 8'h00, 1'b0);
      rd(FB + 16'h6, 8'h00, 1'b0);
      i_fdr_host_model.cyc(1'b1, 1'b1, FB + 16'h4, 8'h00, q, ok);
      chk({7'h0, ok}, 8'h00);
      rd(FB + 16'h4, 8'h81, 1'b1);
      wr(FB + 16'h4, 8'h41);
      chk(rate_select, 8'h41);
      wr(FB + 16'h7, 8'h03);
      chk(config_control, 8'h03);
      disk_change_n = 1'b0;
      rd(FB + 16'h7, 8'h80, 1'b1);
      wr(FB + 16'h2, 8'h0c);
      rd(FB + 16'h2, 8'h0c, 1'b1);
      terminal_count_in = 1'b1;
      core_density_hi = 1'b1;
      settle;
      chk({floppy_irq_oe, core_soft_reset, core_tc, density_select_out, 4'h0}, 8'hb0);
      wr(FB + 16'h2, 8'h04);
      chk({7'h0, floppy_irq_oe}, 8'h00);
      wr(FB + 16'h3, 8'hff);
      rd(FB + 16'h3, 8'h03, 1'b1);
      wr(FB + 16'h5, 8'ha5);
      chk(core_fifo_wr_data, 8'ha5);
      rd(FB + 16'h5, 8'h3c, 1'b1);
      // second interface mode, dma bit still off
      cfg(CR_MODE, 8'h02);
      chk({floppy_irq_oe, density_select_out, core_tc, 5'h0}, 8'h80);
      terminal_count_in = 1'b0;
      settle;
      chk({7'h0, core_tc}, 8'h01);
      for (int i = 0; i < 2; i++) begin
         p = i ? 7'h12 : 7'h6d;
         {core_irq, core_step, track_zero_n, core_head_side, index_pulse_n} = p[6:2];
         {write_protect_n, core_dir_in} = p[1:0];
         rd(FB, {p[6], 1'b1, p[5:0]}, 1'b1);
      end
      // third interface mode, then the first with the enhanced bit set
      cfg(CR_MODE, 8'h00);
      chk({floppy_irq_oe, density_select_out, 6'h0}, 8'h00);
      wr(FB + 16'h2, 8'h0c);
      terminal_count_in = 1'b1;
      settle;
      chk({floppy_irq_oe, core_tc, 6'h0}, 8'hc0);
      cfg(CR_MODE, 8'h23);
      chk({7'h0, enhanced_floppy}, 8'h01);
      wr(FB + 16'h3, 8'hff);
      rd(FB + 16'h3, 8'hff, 1'b1);
      // second reset with the alternate configuration port strapped
      cfg_port_alt = 1'b1;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #2 rst = 1'b0;
      settle;
      settle;
      chk({7'h0, fdc_enabled}, 8'h00);
      cfg(CR_FDC_BASE, 8'h46);
      chk({7'h0, fdc_enabled}, 8'h01);
      print_verdict;
   end
endmodule

bind fdr_top fdr_top_asserts i_fdr_top_asserts (.*);
